// *** rtl/prio_bank_pkg.sv ***
/*
 * constants for the low bank of six interrupt priority words.
 * assumes a 16-bit register port with one-cycle read latency.
 */
`default_nettype none

package prio_bank_pkg;
    localparam int unsigned NUM_WORDS = 6;
    localparam int unsigned NUM_SRC = 24;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned PRIO_W = 3;
    localparam int unsigned SRC_W = 5;

    localparam logic [ADDR_W-1:0] PRIORITY_WORD_0_OFS = 3'h0;
    localparam logic [ADDR_W-1:0] PRIORITY_WORD_1_OFS = 3'h1;
    localparam logic [ADDR_W-1:0] PRIORITY_WORD_2_OFS = 3'h2;
    localparam logic [ADDR_W-1:0] PRIORITY_WORD_3_OFS = 3'h3;
    localparam logic [ADDR_W-1:0] PRIORITY_WORD_4_OFS = 3'h4;
    localparam logic [ADDR_W-1:0] PRIORITY_WORD_5_OFS = 3'h5;

    // field low bit positions within a word
    localparam int unsigned FIELD3_LSB = 12;
    localparam int unsigned FIELD2_LSB = 8;
    localparam int unsigned FIELD1_LSB = 4;
    localparam int unsigned FIELD0_LSB = 0;

    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
    localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;

    // writable masks per word
    localparam logic [DATA_W-1:0] WORD_0_MASK = 16'h7777;
    localparam logic [DATA_W-1:0] WORD_1_MASK = 16'h7770;
    localparam logic [DATA_W-1:0] WORD_2_MASK = 16'h7777;
    localparam logic [DATA_W-1:0] WORD_3_MASK = 16'h0077;
    localparam logic [DATA_W-1:0] WORD_4_MASK = 16'h7777;
    localparam logic [DATA_W-1:0] WORD_5_MASK = 16'h7707;

    // reset values: 3'b100 in every implemented field
    localparam logic [DATA_W-1:0] WORD_0_RESET = 16'h4444;
    localparam logic [DATA_W-1:0] WORD_1_RESET = 16'h4440;
    localparam logic [DATA_W-1:0] WORD_2_RESET = 16'h4444;
    localparam logic [DATA_W-1:0] WORD_3_RESET = 16'h0044;
    localparam logic [DATA_W-1:0] WORD_4_RESET = 16'h4444;
    localparam logic [DATA_W-1:0] WORD_5_RESET = 16'h4404;

    typedef enum logic [2:0] {
        ARB_IDLE = 3'b001,
        ARB_HOLD = 3'b010,
        ARB_UPDATE = 3'b100
    } arb_state_e;
endpackage

`default_nettype wire

// *** rtl/prio_word_reg.sv ***
/*
 * one 16-bit priority word with fixed implemented-bit mask and reset value.
 * assumes write strobe and data on core_clk, synchronous reset.
 */
`default_nettype none

module prio_word_reg
    import prio_bank_pkg::*;
#(
    parameter logic [DATA_W-1:0] MASK = 16'h7777,
    parameter logic [DATA_W-1:0] RESET_VAL = 16'h4444
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [DATA_W-1:0] wr_data,
    output logic [DATA_W-1:0] word
);
    logic [DATA_W-1:0] word_reg;
    logic [DATA_W-1:0] word_next;

    always_comb begin
        word_next = word_reg;
        if (wr_en) begin
            word_next = wr_data & MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            word_reg <= RESET_VAL;
        end else begin
            word_reg <= word_next;
        end
    end

    assign word = word_reg;
endmodule

`default_nettype wire

// *** rtl/prio_arbiter.sv ***
/*
 * combinational pick of the highest level among pending, enabled sources.
 * assumes inputs already synchronised; ties go to the lowest source index.
 */
`default_nettype none

module prio_arbiter
    import prio_bank_pkg::*;
(
    input wire logic [NUM_SRC-1:0] pend,
    input wire logic [NUM_SRC-1:0] enable,
    input wire logic [NUM_SRC*PRIO_W-1:0] levels,
    output logic found,
    output logic [SRC_W-1:0] win_id,
    output logic [PRIO_W-1:0] win_level
);
    always_comb begin
        found = 1'b0;
        win_id = '0;
        win_level = PRIO_OFF;
        for (int i = 0; i < NUM_SRC; i++) begin
            // disabled level never qualifies, nor does a masked request
            if (pend[i] && enable[i] && levels[i*PRIO_W +: PRIO_W] != PRIO_OFF) begin
                // strictly greater keeps the lower index on a tie
                if (levels[i*PRIO_W +: PRIO_W] > win_level) begin
                    found = 1'b1;
                    win_id = SRC_W'(i);
                    win_level = levels[i*PRIO_W +: PRIO_W];
                end
            end
        end
    end
endmodule

`default_nettype wire

// *** rtl/prio_bank.sv ***
/*
 * low bank of interrupt priority words plus the arbitration they feed.
 * assumes a simple register port on core_clk and request/enable lines
 * from peripherals that may be asynchronous to core_clk.
 */
// The strobed register port and the register addresses are this design's own decisions.
`default_nettype none

module prio_bank
    import prio_bank_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [NUM_SRC-1:0] irq_pend,
    input wire logic [NUM_SRC-1:0] irq_enable,
    output logic irq_req,
    output logic [SRC_W-1:0] irq_id,
    output logic [PRIO_W-1:0] irq_level
);
    // ------------------------------------------------------------
    // register words
    // ------------------------------------------------------------
    localparam logic [NUM_WORDS*DATA_W-1:0] MASKS = {WORD_5_MASK, WORD_4_MASK, WORD_3_MASK,
        WORD_2_MASK, WORD_1_MASK, WORD_0_MASK};
    localparam logic [NUM_WORDS*DATA_W-1:0] RESETS = {WORD_5_RESET, WORD_4_RESET, WORD_3_RESET,
        WORD_2_RESET, WORD_1_RESET, WORD_0_RESET};

    logic [DATA_W-1:0] words [NUM_WORDS];

    function automatic logic hits(input logic [ADDR_W-1:0] a, input int unsigned w);
        hits = (a == ADDR_W'(w));
    endfunction

    generate
        for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word
            prio_word_reg #(
                .MASK(MASKS[w*DATA_W +: DATA_W]),
                .RESET_VAL(RESETS[w*DATA_W +: DATA_W])
            ) u_word (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .wr_en(reg_wr && hits(reg_addr, w)),
                .wr_data(reg_wdata),
                .word(words[w])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            for (int w = 0; w < NUM_WORDS; w++) begin
                if (hits(reg_addr, w)) begin
                    rdata_next = words[w];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ------------------------------------------------------------
    // source field map, index order: word 0 low field first
    // ------------------------------------------------------------
    logic [NUM_SRC*PRIO_W-1:0] levels;

    always_comb begin
        levels = '0;
        // word 0: ext irq zero, capture one, compare one, timer one
        levels[0*PRIO_W +: PRIO_W] = words[0][FIELD0_LSB +: PRIO_W];
        levels[1*PRIO_W +: PRIO_W] = words[0][FIELD1_LSB +: PRIO_W];
        levels[2*PRIO_W +: PRIO_W] = words[0][FIELD2_LSB +: PRIO_W];
        levels[3*PRIO_W +: PRIO_W] = words[0][FIELD3_LSB +: PRIO_W];
        // word 1: capture two, compare two, timer two
        levels[4*PRIO_W +: PRIO_W] = words[1][FIELD1_LSB +: PRIO_W];
        levels[5*PRIO_W +: PRIO_W] = words[1][FIELD2_LSB +: PRIO_W];
        levels[6*PRIO_W +: PRIO_W] = words[1][FIELD3_LSB +: PRIO_W];
        // word 2: timer three, sync serial fault, event, serial one rx
        levels[7*PRIO_W +: PRIO_W] = words[2][FIELD0_LSB +: PRIO_W];
        levels[8*PRIO_W +: PRIO_W] = words[2][FIELD1_LSB +: PRIO_W];
        levels[9*PRIO_W +: PRIO_W] = words[2][FIELD2_LSB +: PRIO_W];
        levels[10*PRIO_W +: PRIO_W] = words[2][FIELD3_LSB +: PRIO_W];
        // word 3: serial one tx, converter done
        levels[11*PRIO_W +: PRIO_W] = words[3][FIELD0_LSB +: PRIO_W];
        levels[12*PRIO_W +: PRIO_W] = words[3][FIELD1_LSB +: PRIO_W];
        // word 4: two-wire slave, master, comparator, pin change
        levels[13*PRIO_W +: PRIO_W] = words[4][FIELD0_LSB +: PRIO_W];
        levels[14*PRIO_W +: PRIO_W] = words[4][FIELD1_LSB +: PRIO_W];
        levels[15*PRIO_W +: PRIO_W] = words[4][FIELD2_LSB +: PRIO_W];
        levels[16*PRIO_W +: PRIO_W] = words[4][FIELD3_LSB +: PRIO_W];
        // word 5: ext irq one, capture seven, capture eight
        levels[17*PRIO_W +: PRIO_W] = words[5][FIELD0_LSB +: PRIO_W];
        levels[18*PRIO_W +: PRIO_W] = words[5][FIELD2_LSB +: PRIO_W];
        levels[19*PRIO_W +: PRIO_W] = words[5][FIELD3_LSB +: PRIO_W];
        // indices 20..23 are unmapped, left at level zero (never win)
    end

    // ------------------------------------------------------------
    // request synchronisers
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] pend_meta_reg;
    logic [NUM_SRC-1:0] pend_sync_reg;
    logic [NUM_SRC-1:0] en_meta_reg;
    logic [NUM_SRC-1:0] en_sync_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pend_meta_reg <= '0;
            pend_sync_reg <= '0;
            en_meta_reg <= '0;
            en_sync_reg <= '0;
        end else begin
            pend_meta_reg <= irq_pend;
            pend_sync_reg <= pend_meta_reg;
            en_meta_reg <= irq_enable;
            en_sync_reg <= en_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic found;
    logic [SRC_W-1:0] win_id;
    logic [PRIO_W-1:0] win_level;

    prio_arbiter u_arb (
        .pend(pend_sync_reg),
        .enable(en_sync_reg),
        .levels(levels),
        .found(found),
        .win_id(win_id),
        .win_level(win_level)
    );

    // registered outputs; a changed winner first moves the state to ARB_UPDATE, so a new higher
    // level request replaces the presented one two edges later
    arb_state_e state_reg;
    arb_state_e state_next;
    logic req_reg;
    logic req_next;
    logic [SRC_W-1:0] id_reg;
    logic [SRC_W-1:0] id_next;
    logic [PRIO_W-1:0] level_reg;
    logic [PRIO_W-1:0] level_next;

    always_comb begin
        state_next = state_reg;
        req_next = req_reg;
        id_next = id_reg;
        level_next = level_reg;
        case (state_reg)
            ARB_IDLE: begin
                if (found) begin
                    state_next = ARB_HOLD;
                    req_next = 1'b1;
                    id_next = win_id;
                    level_next = win_level;
                end
            end
            ARB_HOLD: begin
                if (!found) begin
                    state_next = ARB_IDLE;
                    req_next = 1'b0;
                    id_next = '0;
                    level_next = PRIO_OFF;
                end else if (win_id != id_reg || win_level != level_reg) begin
                    state_next = ARB_UPDATE;
                end
            end
            ARB_UPDATE: begin
                state_next = ARB_HOLD;
                req_next = found;
                id_next = found ? win_id : '0;
                level_next = found ? win_level : PRIO_OFF;
                if (!found) begin
                    state_next = ARB_IDLE;
                end
            end
            default: begin
                state_next = ARB_IDLE;
                req_next = 1'b0;
                id_next = '0;
                level_next = PRIO_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= ARB_IDLE;
            req_reg <= 1'b0;
            id_reg <= '0;
            level_reg <= PRIO_OFF;
        end else begin
            state_reg <= state_next;
            req_reg <= req_next;
            id_reg <= id_next;
            level_reg <= level_next;
        end
    end

    assign irq_req = req_reg;
    assign irq_id = id_reg;
    assign irq_level = level_reg;
endmodule

`default_nettype wire

// *** bench/prio_bank_checker.sv ***
/*
 * assertions on the priority bank register port and winner outputs.
 * assumes it is bound to prio_bank and sees only that module's ports.
 */
`default_nettype none

module prio_bank_checker
    import prio_bank_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [NUM_SRC-1:0] irq_pend,
    input wire logic [NUM_SRC-1:0] irq_enable,
    input wire logic irq_req,
    input wire logic [SRC_W-1:0] irq_id,
    input wire logic [PRIO_W-1:0] irq_level
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // ----
    // register port
    // ----
    sequence s_wr0;
        reg_wr && reg_addr == 3'h0;
    endsequence
    sequence s_rd0;
        reg_rd && reg_addr == 3'h0;
    endsequence

    a_unmapped_rd_zero: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_gap_bits_zero: assert property ((reg_rdata & 16'h8888) == 16'h0000)
        else $error("gap bit set");
    // read data stand for one cycle only, zero otherwise
    a_rdata_one_cycle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data without read");
    a_word3_top_empty: assert property (reg_rd && reg_addr == 3'h3 |=> reg_rdata[15:7] == 9'h000)
        else $error("word 3 high bits set");
    a_word5_mid_empty: assert property (reg_rd && reg_addr == 3'h5 |=> reg_rdata[7:3] == 5'h00)
        else $error("word 5 middle bits set");
    a_write_read_back: assert property (s_wr0 ##1 s_rd0 |=> reg_rdata == ($past(reg_wdata, 2) & WORD_0_MASK))
        else $error("read after write mismatch");

    // ----
    // winner outputs
    // ----
    a_req_has_level: assert property (irq_req |-> irq_level != 3'h0)
        else $error("winner at level zero");
    a_idle_level_zero: assert property (!irq_req |-> irq_level == 3'h0)
        else $error("level without request");
    a_spare_never_win: assert property (irq_req |-> irq_id < 5'h14)
        else $error("spare source won");
    // five quiet cycles cover the sync and output stages
    a_no_pend_quiet: assert property ((irq_pend == 24'h000000) [*5] |-> !irq_req)
        else $error("request with nothing pending");
endmodule

bind prio_bank prio_bank_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pend(irq_pend),
    .irq_enable(irq_enable), .irq_req(irq_req), .irq_id(irq_id), .irq_level(irq_level));

`default_nettype wire

// *** bench/prio_bank_tb_top.sv ***
/*
 * self-checking bench for the priority bank and its arbitration.
 * assumes the checker file is compiled alongside and binds itself.
 */
`default_nettype none

module prio_bank_tb_top
    import prio_bank_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [23:0] irq_pend = 24'h000000;
    logic [23:0] irq_enable = 24'h000000;
    logic irq_req;
    logic [4:0] irq_id;
    logic [2:0] irq_level;
    int err_total = 0;
    int samples_checked = 0;
    // per source: word in high nibble, field in low nibble
    logic [7:0] src_map [20] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21, 8'h22,
        8'h23, 8'h30, 8'h31, 8'h40, 8'h41, 8'h42, 8'h43, 8'h50, 8'h52, 8'h53};
    logic [15:0] rst_tab [8] = '{16'h4444, 16'h4440, 16'h4444, 16'h0044, 16'h4444, 16'h4404, 16'h0, 16'h0};
    logic [15:0] msk_tab [8] = '{16'h7777, 16'h7770, 16'h7777, 16'h0077, 16'h7777, 16'h7707, 16'h0, 16'h0};

    prio_bank u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pend(irq_pend),
        .irq_enable(irq_enable), .irq_req(irq_req), .irq_id(irq_id), .irq_level(irq_level));

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    // ----
    // helpers
    // ----
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // strobes stay up until the next call so a write and a read can abut
    task automatic put(input logic w, input logic r, input logic [2:0] a, input logic [15:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask

    task automatic idle(input int n);
        repeat (n) put(1'b0, 1'b0, reg_addr, reg_wdata);
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
        put(1'b0, 1'b1, a, 16'h0000);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check(reg_rdata, e, "read data");
        @(posedge core_clk);
    endtask

    // id reads zero whenever no winner is shown
    task automatic arb_chk(input logic r, input logic [4:0] id, input logic [2:0] l);
        idle(8);
        @(negedge core_clk);
        check({7'h00, irq_req, irq_id, irq_level}, {7'h00, r, id, l}, "winner");
        @(posedge core_clk);
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            rd_chk(3'(i), rst_tab[i]);
        end
    endtask

    task automatic t_masks();
        for (int i = 0; i < 8; i++) begin
            put(1'b1, 1'b0, 3'(i), 16'hffff);
            rd_chk(3'(i), msk_tab[i]);
            put(1'b1, 1'b0, 3'(i), 16'h5a3c);
            rd_chk(3'(i), 16'h5a3c & msk_tab[i]);
        end
    endtask

    task automatic t_map();
        for (int w = 0; w < 6; w++) begin
            put(1'b1, 1'b0, 3'(w), 16'h0000);
        end
        irq_pend <= 24'hffffff;
        irq_enable <= 24'hffffff;
        arb_chk(1'b0, 5'h00, 3'h0);
        for (int s = 0; s < 20; s++) begin
            put(1'b1, 1'b0, src_map[s][6:4], 16'h0007 << (4 * src_map[s][3:0]));
            arb_chk(1'b1, 5'(s), 3'h7);
            put(1'b1, 1'b0, src_map[s][6:4], 16'h0000);
        end
    endtask

    // higher index wins only through its higher level
    task automatic t_levels();
        for (int l = 1; l < 8; l++) begin
            put(1'b1, 1'b0, 3'h0, (16'(l) << 4) | 16'(l - 1));
            arb_chk(1'b1, 5'h01, 3'(l));
        end
    endtask

    task automatic t_enable();
        // equal levels: the lower index takes the grant
        put(1'b1, 1'b0, 3'h0, 16'h0077);
        arb_chk(1'b1, 5'h00, 3'h7);
        put(1'b1, 1'b0, 3'h0, 16'h0017);
        arb_chk(1'b1, 5'h00, 3'h7);
        irq_enable <= 24'hfffffe;
        arb_chk(1'b1, 5'h01, 3'h1);
        irq_pend <= 24'hfffffc;
        arb_chk(1'b0, 5'h00, 3'h0);
        irq_pend <= 24'h000000;
        arb_chk(1'b0, 5'h00, 3'h0);
    endtask

    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_masks();
        // second reset in mid-run must restore written words
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_map();
        t_levels();
        t_enable();
        tally_and_finish();
    end

    // the sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge core_clk);
        err_total++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
